// ===== src/srl_pkg.sv
// shared constants for the latch input selection block
package srl_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_SOURCES = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h2;

  // latch_control fields
  localparam int unsigned CTL_LATCH_EN  = 7;
  localparam int unsigned CTL_DIV_HI    = 6;
  localparam int unsigned CTL_DIV_LO    = 4;
  localparam int unsigned CTL_TRUE_OE   = 3;
  localparam int unsigned CTL_INV_OE    = 2;
  localparam int unsigned CTL_SW_SET    = 1;
  localparam int unsigned CTL_SW_RESET  = 0;

  // latch_source_enables fields
  localparam int unsigned SRC_PIN_SET   = 7;
  localparam int unsigned SRC_CLK_SET   = 6;
  localparam int unsigned SRC_C2_SET    = 5;
  localparam int unsigned SRC_C1_SET    = 4;
  localparam int unsigned SRC_PIN_RESET = 3;
  localparam int unsigned SRC_CLK_RESET = 2;
  localparam int unsigned SRC_C2_RESET  = 1;
  localparam int unsigned SRC_C1_RESET  = 0;

  // status fields
  localparam int unsigned STS_Q         = 0;
  localparam int unsigned STS_C1        = 1;
  localparam int unsigned STS_C2        = 2;
  localparam int unsigned STS_PIN       = 3;

  // reset values
  localparam logic [DATA_W-1:0] RST_CONTROL = 8'h00;
  localparam logic [DATA_W-1:0] RST_SOURCES = 8'h00;

  // divider: code 0 gives a period of 2**2 cycles, code 7 gives 2**9
  localparam int unsigned       DIV_W        = 9;
  localparam int unsigned       DIV_BASE_LOG = 2;
  localparam logic [DIV_W-1:0]  RST_DIV      = 9'h000;

  // software pulse lasts one instruction period
  localparam int unsigned       CLK_PERIOD_NS  = 100;
  localparam int unsigned       INSTR_PERIOD_NS = 400;
  localparam int unsigned       SW_PULSE_CYC =
    (INSTR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned       SW_CNT_W = 3;
  localparam logic [SW_CNT_W-1:0] SW_PULSE_LEN = SW_CNT_W'(SW_PULSE_CYC);
  localparam logic [SW_CNT_W-1:0] RST_SW_CNT   = 3'h0;

endpackage

// ===== src/srl_latch_select.sv
// latch input selection, divider, software pulses, outputs and registers
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns

module srl_latch_select
  import srl_pkg::*;
(
  input  wire logic              clk,                // system clock, 10 MHz
  input  wire logic              sys_rst,            // async reset, active high
  input  wire logic [ADDR_W-1:0] reg_addr,           // register address
  input  wire logic [DATA_W-1:0] reg_wdata,          // write data
  input  wire logic              reg_we,             // write strobe
  input  wire logic              reg_re,             // read strobe
  output logic      [DATA_W-1:0] reg_rdata,          // read data, cycle after strobe
  input  wire logic              comparator_one_raw, // comparator one digital output
  input  wire logic              comparator_two_raw, // comparator two digital output
  input  wire logic              external_latch_input_pin, // external set/reset pin
  output logic                   comparator_one_result, // synced comparator one
  output logic                   comparator_two_result, // synced comparator two
  output logic                   true_output_pin,    // latch output
  output logic                   true_output_pin_oe, // drive enable for true output
  output logic                   inverted_output_pin, // inverted latch output
  output logic                   inverted_output_pin_oe // drive enable for inverted
);

  // synchronisers: first stage read only by second
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic [2:0] nxt_sync;

  always_comb begin
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= 3'h0;
      sync_ff <= 3'h0;
    end else begin
      meta_ff <= {external_latch_input_pin, comparator_two_raw, comparator_one_raw};
      sync_ff <= nxt_sync;
    end
  end

  logic cmp_one;
  logic cmp_two;
  logic pin_in;
  assign cmp_one = sync_ff[0];
  assign cmp_two = sync_ff[1];
  assign pin_in  = sync_ff[2];

  // registers
  logic              latch_enable_ff;
  logic [2:0]        div_sel_ff;
  logic              true_output_enable_ff;
  logic              inverted_output_enable_ff;
  logic [DATA_W-1:0] sources_ff;
  logic              nxt_latch_enable;
  logic [2:0]        nxt_div_sel;
  logic              nxt_true_output_enable;
  logic              nxt_inverted_output_enable;
  logic [DATA_W-1:0] nxt_sources;
  logic [SW_CNT_W-1:0] sw_set_cnt_ff;
  logic [SW_CNT_W-1:0] sw_rst_cnt_ff;
  logic [SW_CNT_W-1:0] nxt_sw_set_cnt;
  logic [SW_CNT_W-1:0] nxt_sw_rst_cnt;
  logic              wr_ctl;
  logic              wr_src;

  assign wr_ctl = reg_we && (reg_addr == OFS_CONTROL);
  assign wr_src = reg_we && (reg_addr == OFS_SOURCES);

  always_comb begin
    nxt_latch_enable           = latch_enable_ff;
    nxt_div_sel                = div_sel_ff;
    nxt_true_output_enable     = true_output_enable_ff;
    nxt_inverted_output_enable = inverted_output_enable_ff;
    nxt_sources                = sources_ff;
    nxt_sw_set_cnt             = (sw_set_cnt_ff != 3'h0) ? sw_set_cnt_ff - 3'h1 : 3'h0;
    nxt_sw_rst_cnt             = (sw_rst_cnt_ff != 3'h0) ? sw_rst_cnt_ff - 3'h1 : 3'h0;
    if (wr_ctl) begin
      nxt_latch_enable           = reg_wdata[CTL_LATCH_EN];
      nxt_div_sel                = reg_wdata[CTL_DIV_HI:CTL_DIV_LO];
      nxt_true_output_enable     = reg_wdata[CTL_TRUE_OE];
      nxt_inverted_output_enable = reg_wdata[CTL_INV_OE];
      // pulse bits are never stored, only start a timed pulse
      if (reg_wdata[CTL_SW_SET]) begin
        nxt_sw_set_cnt = SW_PULSE_LEN;
      end
      if (reg_wdata[CTL_SW_RESET]) begin
        nxt_sw_rst_cnt = SW_PULSE_LEN;
      end
    end else if (wr_src) begin
      nxt_sources = reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      latch_enable_ff           <= RST_CONTROL[CTL_LATCH_EN];
      div_sel_ff                <= RST_CONTROL[CTL_DIV_HI:CTL_DIV_LO];
      true_output_enable_ff     <= RST_CONTROL[CTL_TRUE_OE];
      inverted_output_enable_ff <= RST_CONTROL[CTL_INV_OE];
      sources_ff                <= RST_SOURCES;
      sw_set_cnt_ff             <= RST_SW_CNT;
      sw_rst_cnt_ff             <= RST_SW_CNT;
    end else begin
      latch_enable_ff           <= nxt_latch_enable;
      div_sel_ff                <= nxt_div_sel;
      true_output_enable_ff     <= nxt_true_output_enable;
      inverted_output_enable_ff <= nxt_inverted_output_enable;
      sources_ff                <= nxt_sources;
      sw_set_cnt_ff             <= nxt_sw_set_cnt;
      sw_rst_cnt_ff             <= nxt_sw_rst_cnt;
    end
  end

  // free-running divider; a pulse when the selected low bits are all ones
  logic [DIV_W-1:0] div_cnt_ff;
  logic [DIV_W-1:0] nxt_div_cnt;
  logic [DIV_W-1:0] div_mask;
  logic             divided_clock_pulse;

  always_comb begin
    nxt_div_cnt = div_cnt_ff + 9'h001;
    div_mask    = DIV_W'((10'h001 << (DIV_BASE_LOG + 32'(div_sel_ff))) - 10'h001);
  end

  assign divided_clock_pulse = ((div_cnt_ff & div_mask) == div_mask);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_ff <= RST_DIV;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
    end
  end

  // source selection onto the latch inputs
  logic sw_set;
  logic sw_reset;
  logic set_in;
  logic reset_in;

  assign sw_set   = (sw_set_cnt_ff != 3'h0);
  assign sw_reset = (sw_rst_cnt_ff != 3'h0);

  assign set_in = (sources_ff[SRC_PIN_SET] && pin_in)
               || (sources_ff[SRC_CLK_SET] && divided_clock_pulse)
               || (sources_ff[SRC_C2_SET] && cmp_two)
               || (sources_ff[SRC_C1_SET] && cmp_one)
               || sw_set;

  assign reset_in = (sources_ff[SRC_PIN_RESET] && pin_in)
                 || (sources_ff[SRC_CLK_RESET] && divided_clock_pulse)
                 || (sources_ff[SRC_C2_RESET] && cmp_two)
                 || (sources_ff[SRC_C1_RESET] && cmp_one)
                 || sw_reset;

  // latch state; set wins when both inputs are active
  logic q_ff;
  logic nxt_q;

  always_comb begin
    if (!latch_enable_ff) begin
      nxt_q = 1'b0;
    end else if (set_in) begin
      nxt_q = 1'b1;
    end else if (reset_in) begin
      nxt_q = 1'b0;
    end else begin
      nxt_q = q_ff;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_ff <= 1'b0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // comparator results pass through unchanged: high means plus above minus
  assign comparator_one_result = cmp_one;
  assign comparator_two_result = cmp_two;

  assign true_output_pin        = q_ff;
  assign inverted_output_pin    = !q_ff;
  assign true_output_pin_oe     = latch_enable_ff && true_output_enable_ff;
  assign inverted_output_pin_oe = latch_enable_ff && inverted_output_enable_ff;

  // read path: data only in the cycle after the strobe
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_re) begin
      if (reg_addr == OFS_CONTROL) begin
        // pulse bits always read as zero
        nxt_rdata = {latch_enable_ff, div_sel_ff, true_output_enable_ff,
                     inverted_output_enable_ff, 2'h0};
      end else if (reg_addr == OFS_SOURCES) begin
        nxt_rdata = sources_ff;
      end else if (reg_addr == OFS_STATUS) begin
        nxt_rdata = {4'h0, pin_in, cmp_two, cmp_one, q_ff};
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // checks
  chk_clk_set_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    (latch_enable_ff && sources_ff[SRC_CLK_SET] && divided_clock_pulse) |=> q_ff)
    else $error("divided clock pulse did not set latch");

  chk_cmp_two_set: assert property (@(posedge clk) disable iff (sys_rst)
    (latch_enable_ff && sources_ff[SRC_C2_SET] && cmp_two) |=> q_ff)
    else $error("comparator two did not set latch");

  chk_cmp_one_set: assert property (@(posedge clk) disable iff (sys_rst)
    (latch_enable_ff && sources_ff[SRC_C1_SET] && cmp_one) |=> q_ff)
    else $error("comparator one did not set latch");

  chk_pin_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (sources_ff[SRC_PIN_RESET] && pin_in && !set_in) |=> !q_ff)
    else $error("input pin did not reset latch");

  chk_clk_reset_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    (sources_ff[SRC_CLK_RESET] && divided_clock_pulse && !set_in) |=> !q_ff)
    else $error("divided clock pulse did not reset latch");

  chk_div_fastest_period: assert property (@(posedge clk) disable iff (sys_rst)
    (divided_clock_pulse && div_sel_ff == 3'h0 && !wr_ctl) |=>
      (!divided_clock_pulse)[*3] ##1 (divided_clock_pulse || (div_sel_ff != 3'h0)))
    else $error("divider code zero period is not four cycles");

  chk_output_enables: assert property (@(posedge clk) disable iff (sys_rst)
    (true_output_pin_oe || inverted_output_pin_oe) |-> latch_enable_ff
      && (true_output_pin != inverted_output_pin))
    else $error("output driven while latch disabled");

  chk_disabled_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !latch_enable_ff |=> !q_ff)
    else $error("latch active while disabled");

  chk_sw_pulse_len: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_ctl && reg_wdata[CTL_SW_SET]) |=> sw_set[*4] ##1 (!sw_set || $past(wr_ctl)))
    else $error("software set pulse length wrong");

  chk_pulse_reads_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_re && reg_addr == OFS_CONTROL) |=> (reg_rdata[1:0] == 2'h0))
    else $error("pulse bits read back nonzero");

  chk_sw_reset_len: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_ctl && reg_wdata[CTL_SW_RESET]) |=> sw_reset[*4] ##1 (!sw_reset || $past(wr_ctl)))
    else $error("software reset pulse length wrong");

  // raw level reaches the result after both synchroniser stages
  chk_cmp_one_sync: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(comparator_one_raw) |->
      ##2 (comparator_one_result == $past(comparator_one_raw, 2)))
    else $error("comparator one result does not follow its input");

  chk_cmp_two_sync: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(comparator_two_raw) |->
      ##2 (comparator_two_result == $past(comparator_two_raw, 2)))
    else $error("comparator two result does not follow its input");

  chk_idle_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (latch_enable_ff && !set_in && !reset_in) |=> $stable(q_ff))
    else $error("latch moved with no source active");

  cov_clk_set: cover property (@(posedge clk) disable iff (sys_rst)
    latch_enable_ff && sources_ff[SRC_CLK_SET] && divided_clock_pulse ##1 q_ff);
  cov_cmp_reset: cover property (@(posedge clk) disable iff (sys_rst)
    q_ff ##1 (sources_ff[SRC_C1_RESET] && cmp_one) ##1 !q_ff);
  cov_sw_pulse: cover property (@(posedge clk) disable iff (sys_rst)
    wr_ctl && reg_wdata[CTL_SW_RESET] && latch_enable_ff);
  cov_slow_div: cover property (@(posedge clk) disable iff (sys_rst)
    divided_clock_pulse && div_sel_ff == 3'h7);
  cov_pin_set: cover property (@(posedge clk) disable iff (sys_rst)
    latch_enable_ff && sources_ff[SRC_PIN_SET] && pin_in ##1 q_ff);

endmodule

// ===== bench/srl_far_side.sv
// model of the two comparators and the external pin feeding the latch block
`timescale 1ns/1ns
module srl_far_side (
  input  int          one_plus,                 // comparator one plus input, mV
  input  int          one_minus,                // comparator one minus input, mV
  input  int          two_plus,                 // comparator two plus input, mV
  input  int          two_minus,                // comparator two minus input, mV
  input  wire logic   pin_level,                // level wanted on the pin
  output logic        comparator_one_raw,       // comparator one result
  output logic        comparator_two_raw,       // comparator two result
  output logic        external_latch_input_pin  // external pin
);
  // equal inputs are left to the bench to avoid
  assign comparator_one_raw       = (one_plus > one_minus);
  assign comparator_two_raw       = (two_plus > two_minus);
  assign external_latch_input_pin = pin_level;
endmodule

// ===== bench/srl_latch_select_bench.sv
// self-checking bench for the latch input selection block
`timescale 1ns/1ns
module srl_latch_select_bench
  import srl_pkg::*;
;
  typedef struct packed {
    logic [7:0] src;
    logic       c1;
    logic       c2;
    logic       pin;
    logic       pre;
    logic       q;
  } srl_row_t;

  logic              clk       = 1'b0;
  logic              sys_rst   = 1'b1;
  logic [ADDR_W-1:0] reg_addr  = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_we    = 1'b0;
  logic              reg_re    = 1'b0;
  logic              pin_level = 1'b0;
  int                one_plus  = 0;
  int                two_plus  = 0;
  logic [DATA_W-1:0] reg_rdata;
  logic              c1_raw, c2_raw, pin_raw, c1_res, c2_res;
  logic              q_pin, q_oe, nq_pin, nq_oe;
  logic [DATA_W-1:0] d;
  logic [15:0]       exp_st;
  int                n;
  int                errors     = 0;
  int                n_compared = 0;
  // sources, c1, c2, pin, preset, expected q
  srl_row_t          rows [11] = '{
    {8'h80, 5'b00101}, {8'h40, 5'b00001}, {8'h20, 5'b01001}, {8'h10, 5'b10001},
    {8'h20, 5'b10000}, {8'h08, 5'b00110}, {8'h04, 5'b00010}, {8'h02, 5'b01010},
    {8'h01, 5'b10010}, {8'h00, 5'b11111}, {8'h0f, 5'b11100}};
  // rows: and hold

  always #50 clk = ~clk;

  srl_far_side far_u (
    .one_plus                 (one_plus),
    .one_minus                (1),
    .two_plus                 (two_plus),
    .two_minus                (1),
    .pin_level                (pin_level),
    .comparator_one_raw       (c1_raw),
    .comparator_two_raw       (c2_raw),
    .external_latch_input_pin (pin_raw)
  );

  srl_latch_select dut_u (
    .clk                      (clk),
    .sys_rst                  (sys_rst),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_we                   (reg_we),
    .reg_re                   (reg_re),
    .reg_rdata                (reg_rdata),
    .comparator_one_raw       (c1_raw),
    .comparator_two_raw       (c2_raw),
    .external_latch_input_pin (pin_raw),
    .comparator_one_result    (c1_res),
    .comparator_two_result    (c2_res),
    .true_output_pin          (q_pin),
    .true_output_pin_oe       (q_oe),
    .inverted_output_pin      (nq_pin),
    .inverted_output_pin_oe   (nq_oe)
  );

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re   <= 1'b0;
    #50;
    v = reg_rdata;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // counts edges until the true output rises, bounded
  task automatic rise(output int k);
    k = 0;
    while (q_pin !== 1'b0 && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    while (q_pin !== 1'b1 && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  task automatic results;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(20000 * 100);
    errors++;
    results();
  end

  initial begin
    cyc(5);
    sys_rst <= 1'b0;
    cyc(1);
    #1;
    chk("pins", 16'({q_oe, nq_oe, q_pin, nq_pin}), 16'h0001);
    rd(OFS_CONTROL, d);
    chk("control", 16'(d), 16'(RST_CONTROL));
    rd(OFS_SOURCES, d);
    chk("sources", 16'(d), 16'(RST_SOURCES));
    rd(4'hf, d);
    chk("unmapped", 16'(d), 16'h0000);
    foreach (rows[i]) begin
      wr(OFS_SOURCES, 8'h00);
      wr(OFS_CONTROL, 8'h00);
      one_plus  <= rows[i].c1 ? 2 : 0;
      two_plus  <= rows[i].c2 ? 2 : 0;
      pin_level <= rows[i].pin;
      wr(OFS_CONTROL, {6'h20, rows[i].pre, 1'b0});
      cyc(7);
      wr(OFS_SOURCES, rows[i].src);
      cyc(7);
      rd(OFS_STATUS, d);
      exp_st = 16'({4'h0, rows[i].pin, rows[i].c2, rows[i].c1, rows[i].q});
      chk("status", 16'(d), exp_st);
      chk("c_results", 16'({c2_res, c1_res}), 16'({rows[i].c2, rows[i].c1}));
    end
    // enable gates both drive enables
    for (int k = 0; k < 8; k++) begin
      wr(OFS_CONTROL, {k[2], 3'h0, k[1], k[0], 2'h0});
      cyc(1);
      #1;
      chk("oe", 16'({q_oe, nq_oe}), 16'({k[2] & k[1], k[2] & k[0]}));
    end
    wr(OFS_SOURCES, 8'h00);
    wr(OFS_CONTROL, 8'h82);
    rd(OFS_CONTROL, d);
    chk("sw_readback", 16'(d), 16'h0080);
    chk("sw_set", 16'(q_pin), 16'h0001);
    chk("sw_set_inv", 16'(nq_pin), 16'h0000);
    wr(OFS_CONTROL, 8'h81);
    cyc(2);
    #1;
    chk("sw_reset", 16'(q_pin), 16'h0000);
    // set on the divided pulse, pin reset clears it the cycle after
    cyc(1);
    pin_level <= 1'b1;
    wr(OFS_SOURCES, 8'h48);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CONTROL, {1'b1, c[2:0], 4'h0});
      repeat (3) rise(n);
      chk("period", 16'(n), 16'(4 << c));
      cyc(1);
      #1;
      chk("pulse_width", 16'(q_pin), 16'h0000);
    end
    cyc(1);
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    rd(OFS_SOURCES, d);
    chk("sources_rerst", 16'(d), 16'(RST_SOURCES));
    chk("pins_rerst", 16'({q_oe, nq_oe, q_pin, nq_pin}), 16'h0001);
    results();
  end
endmodule
